/* File: shared/adcc_pkg.sv */
// Purpose: constants, types and helpers for the converter control block
// Assumes: one clock domain, times counted in converter-clock half periods
// Notes: half-period counts start at the converter clock edge that opens a conversion
package adcc_pkg;

	localparam int RESULT_WIDTH = 10;
	localparam int BYTE_WIDTH = 8;
	localparam int PAD_WIDTH = 2 * BYTE_WIDTH - RESULT_WIDTH;
	localparam int CHANNEL_WIDTH = 4;
	localparam int REFERENCE_WIDTH = 2;
	localparam int SELECT_WIDTH = 3;
	localparam int PRESCALE_WIDTH = 8;
	localparam int HALF_WIDTH = 6;
	localparam int SYNC_WIDTH = 2;

	// trigger source codes
	localparam logic [SELECT_WIDTH-1:0] TRIG_FREE_RUNNING = 3'h0;
	localparam logic [SELECT_WIDTH-1:0] TRIG_COMPARATOR = 3'h1;
	localparam logic [SELECT_WIDTH-1:0] TRIG_EXT_IRQ0 = 3'h2;
	localparam logic [SELECT_WIDTH-1:0] TRIG_T0_COMPARE_A = 3'h3;
	localparam logic [SELECT_WIDTH-1:0] TRIG_T0_OVERFLOW = 3'h4;
	localparam logic [SELECT_WIDTH-1:0] TRIG_T1_COMPARE_B = 3'h5;
	localparam logic [SELECT_WIDTH-1:0] TRIG_T1_OVERFLOW = 3'h6;
	localparam logic [SELECT_WIDTH-1:0] TRIG_T1_CAPTURE = 3'h7;

	// conversion timing in converter-clock half periods
	localparam logic [HALF_WIDTH-1:0] NORMAL_SAMPLE_HALVES = 6'h03;
	localparam logic [HALF_WIDTH-1:0] NORMAL_END_HALVES = 6'h1a;
	localparam logic [HALF_WIDTH-1:0] FIRST_SAMPLE_HALVES = 6'h1b;
	localparam logic [HALF_WIDTH-1:0] FIRST_END_HALVES = 6'h32;
	localparam logic [HALF_WIDTH-1:0] AUTO_SAMPLE_HALVES = 6'h04;
	localparam logic [HALF_WIDTH-1:0] AUTO_END_HALVES = 6'h1b;
	localparam logic [HALF_WIDTH-1:0] LAST_CYCLE_HALVES = 6'h02;
	localparam logic [HALF_WIDTH-1:0] HALF_STEP = 6'h01;

	// trigger synchronisation in cpu clock cycles
	localparam logic [SYNC_WIDTH-1:0] SYNC_LAST = 2'h2;
	localparam logic [SYNC_WIDTH-1:0] SYNC_STEP = 2'h1;

	// prescaler
	localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_ONE = 8'h01;
	localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_MIN = 8'h02;

	typedef enum logic [1:0] {
		CONV_IDLE = 2'b00,
		CONV_WAIT_EDGE = 2'b01,
		CONV_SYNC = 2'b10,
		CONV_RUN = 2'b11
	} adcc_state_type;

	// division ratio of the converter clock
	function automatic logic [PRESCALE_WIDTH-1:0] prescaleDivide(input logic [SELECT_WIDTH-1:0] sel);
		logic [PRESCALE_WIDTH-1:0] d;
		d = PRESCALE_ONE << sel;
		if (d < PRESCALE_MIN) begin
			d = PRESCALE_MIN;
		end
		return d;
	endfunction

	function automatic logic [HALF_WIDTH-1:0] endHalves(input logic first, input logic auto);
		if (first) begin
			return FIRST_END_HALVES;
		end
		return auto ? AUTO_END_HALVES : NORMAL_END_HALVES;
	endfunction

	function automatic logic [HALF_WIDTH-1:0] sampleHalves(input logic first, input logic auto);
		if (first) begin
			return FIRST_SAMPLE_HALVES;
		end
		return auto ? AUTO_SAMPLE_HALVES : NORMAL_SAMPLE_HALVES;
	endfunction

endpackage

/* File: shared/adcc_result_if.sv */
// Purpose: carries completed results and byte reads to the result store
// Assumes: single clock domain
// Notes: ctrl drives writes and reads, store answers with bytes and lock
`timescale 1ns/10ps
`default_nettype none
interface adcc_result_if;
	import adcc_pkg::*;
	logic writeStrobe;
	logic [RESULT_WIDTH-1:0] value;
	logic leftAdjust;
	logic lowRead;
	logic highRead;
	logic [BYTE_WIDTH-1:0] highByte;
	logic [BYTE_WIDTH-1:0] lowByte;
	logic locked;
	modport ctrl(output writeStrobe, value, leftAdjust, lowRead, highRead, input highByte, lowByte, locked);
	modport store(input writeStrobe, value, leftAdjust, lowRead, highRead, output highByte, lowByte, locked);
endinterface
`default_nettype wire

/* File: verilog/adcc_result_store.sv */
// Purpose: result byte pair with low-then-high read lock
// Assumes: reads and writes are single-cycle pulses on clk
// Notes: a high read in the same cycle as a completion lets that result in
`timescale 1ns/10ps
`default_nettype none
module adcc_result_store
	import adcc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	// result path
	adcc_result_if.store res
);

	logic [2*BYTE_WIDTH-1:0] placed;
	logic writeAllowed;

	////////////////////////////////////////////////////////////////////////
	// placement of the result inside the byte pair
	always_comb begin
		if (res.leftAdjust) begin
			placed = {res.value, {PAD_WIDTH{1'b0}}};
		end else begin
			placed = {{PAD_WIDTH{1'b0}}, res.value};
		end
	end

	assign writeAllowed = res.writeStrobe && (!res.locked || res.highRead);

	////////////////////////////////////////////////////////////////////////
	// lock between low and high reads
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			res.locked <= 1'b0;
		end else if (clkEn) begin
			if (res.highRead) begin
				res.locked <= 1'b0;
			end else if (res.lowRead) begin
				res.locked <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			res.highByte <= '0;
			res.lowByte <= '0;
		end else if (clkEn && writeAllowed) begin
			res.highByte <= placed[2*BYTE_WIDTH-1:BYTE_WIDTH];
			res.lowByte <= placed[BYTE_WIDTH-1:0];
		end
	end

endmodule
`default_nettype wire

/* File: verilog/adcc_conversion_control.sv */
// Purpose: control of a successive-approximation converter: prescaler, starts, timing, flag, results
// Assumes: trigger flags and control bits come from logic on clk; analog core result is stable at completion
// Notes: all state freezes while clkEn is low
`timescale 1ns/10ps
`default_nettype none
module adcc_conversion_control
	import adcc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	// software control bits
	input wire logic converterPowerReduce,
	input wire logic converterEnable,
	input wire logic startConversionWrite,
	input wire logic autoTriggerEnable,
	input wire logic [SELECT_WIDTH-1:0] triggerSourceSelect,
	input wire logic [SELECT_WIDTH-1:0] prescalerSelect,
	input wire logic leftAdjustResult,
	input wire logic [CHANNEL_WIDTH-1:0] channelSelect,
	input wire logic [REFERENCE_WIDTH-1:0] referenceSelect,
	// software flag and result access
	input wire logic doneFlagClearWrite,
	input wire logic doneIrqEnable,
	input wire logic irqVectorTaken,
	input wire logic resultLowRead,
	input wire logic resultHighRead,
	// trigger source flags
	input wire logic comparatorFlag,
	input wire logic extIrq0Flag,
	input wire logic timer0CompareAFlag,
	input wire logic timer0OverflowFlag,
	input wire logic timer1CompareBFlag,
	input wire logic timer1OverflowFlag,
	input wire logic timer1CaptureFlag,
	// analog core
	input wire logic [RESULT_WIDTH-1:0] analogResult,
	// status to software
	output logic startConversion,
	output logic conversionDoneFlag,
	output logic doneIrqRequest,
	output logic [BYTE_WIDTH-1:0] resultHighByte,
	output logic [BYTE_WIDTH-1:0] resultLowByte,
	output logic resultLocked,
	// controls to analog core
	output logic analogPowerOn,
	output logic [CHANNEL_WIDTH-1:0] appliedChannel,
	output logic [REFERENCE_WIDTH-1:0] appliedReference,
	output logic sampleHold,
	output logic sarClockTick,
	output logic sarFirstConversion
);

	adcc_result_if resIf();

	logic active;
	logic activePrev_q;
	logic [PRESCALE_WIDTH-1:0] prescaleCount_q;
	logic [PRESCALE_WIDTH-1:0] divide;
	logic tickFull;
	logic tickHalf;
	logic tickAny;
	logic triggerSignal;
	logic triggerPrev_q;
	logic triggerEdge;
	logic triggerFire;
	logic freeRunning;
	logic complete;
	logic [HALF_WIDTH-1:0] halfNext;
	logic [HALF_WIDTH-1:0] endPoint;
	logic [HALF_WIDTH-1:0] samplePoint;
	logic selectionFrozen;
	adcc_state_type state_q;
	adcc_state_type state_d;
	logic [HALF_WIDTH-1:0] halfCount_q;
	logic [HALF_WIDTH-1:0] halfCount_d;
	logic [SYNC_WIDTH-1:0] syncCount_q;
	logic [SYNC_WIDTH-1:0] syncCount_d;
	logic auto_q;
	logic auto_d;
	logic first_q;
	logic doneFlag_d;

	////////////////////////////////////////////////////////////////////////
	// enable qualification
	assign active = converterEnable && !converterPowerReduce;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			activePrev_q <= 1'b0;
			analogPowerOn <= 1'b0;
		end else if (clkEn) begin
			activePrev_q <= active;
			analogPowerOn <= active;
		end
	end

	// first conversion after switch-on uses the long timing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			first_q <= 1'b0;
		end else if (clkEn) begin
			if (active && !activePrev_q) begin
				first_q <= 1'b1;
			end else if (complete || !active) begin
				first_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// prescaler
	assign divide = prescaleDivide(prescalerSelect);
	assign tickFull = active && !triggerFire && (prescaleCount_q >= divide - PRESCALE_ONE);
	assign tickHalf = active && !triggerFire && (prescaleCount_q == (divide >> 1) - PRESCALE_ONE);
	assign tickAny = tickFull || tickHalf;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prescaleCount_q <= '0;
		end else if (clkEn) begin
			if (!active) begin
				prescaleCount_q <= '0;
			end else if (triggerFire) begin
				prescaleCount_q <= '0;
			end else if (tickFull) begin
				prescaleCount_q <= '0;
			end else begin
				prescaleCount_q <= prescaleCount_q + PRESCALE_ONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// trigger selection and edge detection
	always_comb begin
		case (triggerSourceSelect)
			TRIG_FREE_RUNNING: triggerSignal = 1'b0;
			TRIG_COMPARATOR: triggerSignal = comparatorFlag;
			TRIG_EXT_IRQ0: triggerSignal = extIrq0Flag;
			TRIG_T0_COMPARE_A: triggerSignal = timer0CompareAFlag;
			TRIG_T0_OVERFLOW: triggerSignal = timer0OverflowFlag;
			TRIG_T1_COMPARE_B: triggerSignal = timer1CompareBFlag;
			TRIG_T1_OVERFLOW: triggerSignal = timer1OverflowFlag;
			TRIG_T1_CAPTURE: triggerSignal = timer1CaptureFlag;
			default: triggerSignal = 1'b0;
		endcase
	end

	// previous value of the selected signal, so a source switch can make an edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			triggerPrev_q <= 1'b0;
		end else if (clkEn) begin
			triggerPrev_q <= triggerSignal;
		end
	end

	// the source flag must fall before another edge is seen
	assign triggerEdge = autoTriggerEnable && active && triggerSignal && !triggerPrev_q
		&& (state_q == CONV_IDLE);
	assign triggerFire = (state_q == CONV_SYNC) && (syncCount_q == SYNC_LAST);
	assign freeRunning = autoTriggerEnable && (triggerSourceSelect == TRIG_FREE_RUNNING);

	////////////////////////////////////////////////////////////////////////
	// conversion sequencer
	assign endPoint = endHalves(first_q, auto_q);
	assign samplePoint = sampleHalves(first_q, auto_q);
	assign halfNext = halfCount_q + HALF_STEP;
	assign complete = (state_q == CONV_RUN) && tickAny && (halfNext == endPoint);

	always_comb begin
		state_d = state_q;
		halfCount_d = halfCount_q;
		syncCount_d = syncCount_q;
		auto_d = auto_q;
		case (state_q)
			CONV_IDLE: begin
				if (startConversionWrite && active) begin
					state_d = CONV_WAIT_EDGE;
					auto_d = 1'b0;
				end else if (triggerEdge) begin
					state_d = CONV_SYNC;
					syncCount_d = '0;
				end
			end
			CONV_WAIT_EDGE: begin
				if (tickFull) begin
					state_d = CONV_RUN;
					halfCount_d = '0;
				end
			end
			CONV_SYNC: begin
				if (triggerFire) begin
					state_d = CONV_RUN;
					halfCount_d = '0;
					auto_d = 1'b1;
				end else begin
					syncCount_d = syncCount_q + SYNC_STEP;
				end
			end
			CONV_RUN: begin
				if (complete) begin
					if (freeRunning) begin
						state_d = CONV_RUN;
						halfCount_d = '0;
						auto_d = 1'b0;
					end else begin
						state_d = CONV_IDLE;
					end
				end else if (tickAny) begin
					halfCount_d = halfNext;
				end
			end
			default: begin
				state_d = CONV_IDLE;
			end
		endcase
		if (!active) begin
			state_d = CONV_IDLE;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= CONV_IDLE;
			halfCount_q <= '0;
			syncCount_q <= '0;
			auto_q <= 1'b0;
		end else if (clkEn) begin
			state_q <= state_d;
			halfCount_q <= halfCount_d;
			syncCount_q <= syncCount_d;
			auto_q <= auto_d;
		end
	end

	// start bit mirrors any conversion in progress, however it began
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			startConversion <= 1'b0;
		end else if (clkEn) begin
			startConversion <= (state_d != CONV_IDLE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// analog core strobes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sampleHold <= 1'b0;
			sarClockTick <= 1'b0;
			sarFirstConversion <= 1'b0;
		end else if (clkEn) begin
			sampleHold <= (state_q == CONV_RUN) && tickAny && (halfNext == samplePoint);
			sarClockTick <= (state_q == CONV_RUN) && tickFull;
			sarFirstConversion <= first_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// channel and reference buffer
	assign selectionFrozen = (state_q == CONV_RUN) && (halfCount_q < endPoint - LAST_CYCLE_HALVES);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			appliedChannel <= '0;
			appliedReference <= '0;
		end else if (clkEn) begin
			if (!active) begin
				appliedChannel <= '0;
				appliedReference <= '0;
			end else if (!selectionFrozen) begin
				appliedChannel <= channelSelect;
				appliedReference <= referenceSelect;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// completion flag and interrupt request
	always_comb begin
		doneFlag_d = conversionDoneFlag;
		if (doneFlagClearWrite || irqVectorTaken) begin
			doneFlag_d = 1'b0;
		end
		if (complete) begin
			doneFlag_d = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conversionDoneFlag <= 1'b0;
			doneIrqRequest <= 1'b0;
		end else if (clkEn) begin
			conversionDoneFlag <= doneFlag_d;
			doneIrqRequest <= doneFlag_d && doneIrqEnable;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// result bytes
	assign resIf.writeStrobe = complete;
	assign resIf.value = analogResult;
	assign resIf.leftAdjust = leftAdjustResult;
	assign resIf.lowRead = resultLowRead;
	assign resIf.highRead = resultHighRead;
	assign resultHighByte = resIf.highByte;
	assign resultLowByte = resIf.lowByte;
	assign resultLocked = resIf.locked;

	adcc_result_store resultStore (
		.clk(clk),
		.rst(rst),
		.clkEn(clkEn),
		.res(resIf.store)
	);

endmodule
`default_nettype wire

/* File: sim/adcc_trigger_model.sv */
// Purpose: trigger sources on the far side: seven interrupt flags
// Assumes: one clock; raise and clear are one-cycle commands
// Notes: a flag stays set until software clears it, masked or not
`timescale 1ns/10ps
`default_nettype none
module adcc_trigger_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// commands
	input wire logic raise,
	input wire logic clear,
	input wire logic [2:0] idx,
	// flags, bit n for source code n
	output logic [7:0] flags
);
	logic [7:0] flags_q;
	assign flags = flags_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_q <= 8'h00;
		end else if (raise) begin
			flags_q <= flags_q | (8'h01 << idx);
		end else if (clear) begin
			flags_q <= flags_q & ~(8'h01 << idx);
		end
	end
endmodule
`default_nettype wire

/* File: sim/adcc_conversion_control_props.sv */
// Purpose: port-level checks of the converter control block
// Assumes: one clock domain
// Notes: bound to every instance of the top module
`timescale 1ns/10ps
`default_nettype none
module adcc_conversion_control_props
	import adcc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	// software side
	input wire logic converterPowerReduce,
	input wire logic converterEnable,
	input wire logic startConversionWrite,
	input wire logic autoTriggerEnable,
	input wire logic [SELECT_WIDTH-1:0] triggerSourceSelect,
	input wire logic doneFlagClearWrite,
	input wire logic doneIrqEnable,
	input wire logic irqVectorTaken,
	input wire logic resultLowRead,
	input wire logic resultHighRead,
	// status
	input wire logic startConversion,
	input wire logic conversionDoneFlag,
	input wire logic doneIrqRequest,
	input wire logic [BYTE_WIDTH-1:0] resultHighByte,
	input wire logic [BYTE_WIDTH-1:0] resultLowByte,
	input wire logic resultLocked,
	input wire logic analogPowerOn,
	input wire logic [CHANNEL_WIDTH-1:0] appliedChannel,
	input wire logic sampleHold
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire logic active = converterEnable && !converterPowerReduce;
	////////////////////////////////////////////////////////////////////////
	start_taken_a: assert property (startConversionWrite && clkEn && active && !startConversion
		|=> startConversion)
		else $error("start write not taken");
	off_idle_a: assert property ((!active && clkEn) [*2]
		|=> !startConversion && !analogPowerOn && appliedChannel == 4'h0)
		else $error("inactive converter still running");
	done_sets_a: assert property ($fell(startConversion) && $past(active) |-> conversionDoneFlag)
		else $error("start cleared without done flag");
	free_run_a: assert property ($rose(conversionDoneFlag) && $past(autoTriggerEnable)
		&& $past(active) && $past(triggerSourceSelect) == TRIG_FREE_RUNNING |-> startConversion)
		else $error("free running stopped");
	flag_clear_a: assert property ((doneFlagClearWrite || irqVectorTaken) && clkEn && !startConversion
		|=> !conversionDoneFlag)
		else $error("done flag not cleared");
	flag_hold_a: assert property (conversionDoneFlag && !doneFlagClearWrite && !irqVectorTaken
		|=> conversionDoneFlag)
		else $error("done flag lost");
	irq_level_a: assert property ($past(clkEn)
		|-> doneIrqRequest == (conversionDoneFlag && $past(doneIrqEnable)))
		else $error("interrupt request wrong");
	lock_set_a: assert property (resultLowRead && !resultHighRead && clkEn |=> resultLocked)
		else $error("low read did not lock");
	lock_free_a: assert property (resultHighRead && clkEn |=> !resultLocked)
		else $error("high read did not unlock");
	lock_hold_a: assert property (resultLocked && !resultHighRead
		|=> $stable(resultHighByte) && $stable(resultLowByte))
		else $error("locked result changed");
	sample_busy_a: assert property (sampleHold |-> startConversion)
		else $error("sample outside conversion");
	cover property ($fell(startConversion));
	cover property ($rose(resultLocked));
	cover property ($rose(conversionDoneFlag) && startConversion);
endmodule
bind adcc_conversion_control adcc_conversion_control_props u_props (.*);
`default_nettype wire

/* File: sim/adcc_conversion_control_test.sv */
// Purpose: self-checking bench for the converter control block
// Assumes: prescaler select 1 or 2, one converter clock is 2 or 4 cycles
// Notes: software strobes come from one pulse task, trigger flags from the model
`timescale 1ns/10ps
`default_nettype none
module adcc_conversion_control_test;
	import adcc_pkg::*;
	localparam logic [6:0] P_START = 7'h01, P_CLR = 7'h02, P_VEC = 7'h04, P_LOW = 7'h08;
	localparam logic [6:0] P_HIGH = 7'h10, P_RAISE = 7'h20, P_DROP = 7'h40;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic clkEn = 1'b1;
	logic converterPowerReduce = 1'b0;
	logic converterEnable = 1'b1;
	logic autoTriggerEnable = 1'b0;
	logic [SELECT_WIDTH-1:0] triggerSourceSelect = 3'h0;
	logic [SELECT_WIDTH-1:0] prescalerSelect = 3'h1;
	logic leftAdjustResult = 1'b0;
	logic [CHANNEL_WIDTH-1:0] channelSelect = 4'h0;
	logic [REFERENCE_WIDTH-1:0] referenceSelect = 2'h0;
	logic doneIrqEnable = 1'b0;
	logic [RESULT_WIDTH-1:0] analogResult = 10'h2d5;
	logic [6:0] strobe = 7'h00;
	logic [2:0] trgIdx = 3'h0;
	logic [7:0] trigFlags;
	wire logic startConversionWrite = strobe[0];
	wire logic doneFlagClearWrite = strobe[1];
	wire logic irqVectorTaken = strobe[2];
	wire logic resultLowRead = strobe[3];
	wire logic resultHighRead = strobe[4];
	logic startConversion, conversionDoneFlag, doneIrqRequest, resultLocked;
	logic analogPowerOn, sampleHold, sarClockTick, sarFirstConversion;
	logic [BYTE_WIDTH-1:0] resultHighByte, resultLowByte;
	logic [CHANNEL_WIDTH-1:0] appliedChannel;
	logic [REFERENCE_WIDTH-1:0] appliedReference;
	int n_mismatch = 0;
	int total_checks = 0;
	int cycles = 0;
	////////////////////////////////////////////////////////////////////////
	adcc_trigger_model u_adcc_trigger_model (.clk(clk), .rst(rst), .raise(strobe[5]), .clear(strobe[6]),
		.idx(trgIdx), .flags(trigFlags));
	adcc_conversion_control u_adcc_conversion_control (.*, .comparatorFlag(trigFlags[1]),
		.extIrq0Flag(trigFlags[2]), .timer0CompareAFlag(trigFlags[3]), .timer0OverflowFlag(trigFlags[4]),
		.timer1CompareBFlag(trigFlags[5]), .timer1OverflowFlag(trigFlags[6]), .timer1CaptureFlag(trigFlags[7]));
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task pulse(input logic [6:0] m);
		strobe <= m;
		tick(1);
		strobe <= 7'h00;
		tick(1);
	endtask
	task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// waits for busy, then counts busy cycles and sample pulses; lo 0 skips the sample count
	task expectBusy(input string what, input int lo, input int hi);
		int n;
		int samples;
		n = 0;
		samples = 0;
		while (startConversion !== 1'b1 && n < 12) begin
			tick(1);
			n++;
		end
		n = 0;
		while (startConversion === 1'b1 && n < 400) begin
			tick(1);
			samples += sampleHold;
			n++;
		end
		check(what, (n >= lo && n <= hi), 1'b1);
		if (lo > 0) begin
			check("sample pulses", samples, 1);
		end
	endtask
	task expectBytes(input logic [7:0] h, input logic [7:0] l);
		check("result bytes", {resultHighByte, resultLowByte}, {h, l});
	endtask
	task done(input string name);
		$display("test %s finished", name);
	endtask
	task results;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		tick(5);
		rst <= 1'b0;
		tick(1);
		check("reset state", {startConversion, conversionDoneFlag, resultLocked, resultHighByte}, 0);
		done("reset");
		pulse(P_START);
		expectBusy("first conversion", 49, 55);
		check("done flag", conversionDoneFlag, 1'b1);
		expectBytes(8'h02, 8'hd5);
		leftAdjustResult <= 1'b1;
		for (int d = 2; d >= 1; d--) begin
			prescalerSelect <= 3'(d);
			pulse(P_CLR | P_START);
			expectBusy("normal conversion", (13 << d) - 1, (13 << d) + (1 << d) + 3);
			check("done flag", conversionDoneFlag, 1'b1);
		end
		expectBytes(8'hb5, 8'h40);
		done("timing");
		leftAdjustResult <= 1'b0;
		analogResult <= 10'h13c;
		pulse(P_LOW);
		pulse(P_CLR | P_START);
		expectBusy("locked conversion", 25, 31);
		check("flag while locked", conversionDoneFlag, 1'b1);
		expectBytes(8'hb5, 8'h40);
		pulse(P_HIGH);
		check("lock released", resultLocked, 1'b0);
		pulse(P_CLR | P_START);
		expectBusy("unlocked conversion", 25, 31);
		expectBytes(8'h01, 8'h3c);
		done("result lock");
		channelSelect <= 4'h3;
		referenceSelect <= 2'h1;
		tick(3);
		check("applied idle", {appliedReference, appliedChannel}, 6'h13);
		pulse(P_START);
		tick(8);
		channelSelect <= 4'h9;
		tick(3);
		check("channel frozen", appliedChannel, 4'h3);
		expectBusy("rest of conversion", 0, 40);
		check("channel after", appliedChannel, 4'h9);
		doneIrqEnable <= 1'b1;
		tick(2);
		check("irq raised", doneIrqRequest, 1'b1);
		pulse(P_VEC);
		check("vector clears", {conversionDoneFlag, doneIrqRequest}, 2'b00);
		doneIrqEnable <= 1'b0;
		done("selection and interrupt");
		autoTriggerEnable <= 1'b1;
		for (int s = 1; s < 8; s++) begin
			trgIdx <= 3'(s);
			if (s[0]) begin
				triggerSourceSelect <= 3'(s);
				pulse(P_CLR);
				pulse(P_RAISE);
			end else begin
				pulse(P_CLR | P_RAISE);
				triggerSourceSelect <= 3'(s);
			end
			expectBusy("triggered conversion", 27, 35);
			check("masked flag", {doneIrqRequest, conversionDoneFlag}, 2'b01);
			tick(40);
			check("level retrigger", startConversion, 1'b0);
			pulse(P_DROP);
		end
		done("auto trigger");
		triggerSourceSelect <= TRIG_FREE_RUNNING;
		tick(20);
		check("free select idle", startConversion, 1'b0);
		pulse(P_START);
		repeat (2) begin
			pulse(P_CLR);
			while (conversionDoneFlag !== 1'b1 && cycles < 19000) begin
				tick(1);
			end
			check("free run busy", startConversion, 1'b1);
		end
		triggerSourceSelect <= TRIG_COMPARATOR;
		expectBusy("free run stop", 0, 40);
		pulse(P_START);
		expectBusy("start under auto", 25, 31);
		autoTriggerEnable <= 1'b0;
		done("free running");
		converterPowerReduce <= 1'b1;
		tick(3);
		check("power reduced", {analogPowerOn, appliedChannel}, 0);
		pulse(P_START);
		tick(2);
		check("start refused", startConversion, 1'b0);
		converterPowerReduce <= 1'b0;
		converterEnable <= 1'b0;
		tick(3);
		check("disabled", {analogPowerOn, appliedChannel}, 0);
		converterEnable <= 1'b1;
		tick(3);
		pulse(P_START);
		check("first timing", sarFirstConversion, 1'b1);
		expectBusy("first after enable", 49, 55);
		done("enable");
		// a frozen clock enable must stretch a running conversion
		pulse(P_CLR | P_START);
		tick(12);
		clkEn <= 1'b0;
		tick(30);
		check("frozen conversion", {startConversion, conversionDoneFlag}, 2'b10);
		clkEn <= 1'b1;
		expectBusy("thawed conversion", 0, 18);
		check("done after thaw", conversionDoneFlag, 1'b1);
		done("clock enable");
		results();
	end
endmodule
`default_nettype wire
